/* rtl/tks_defines.svh */
// constants for the touch key scan control block
`ifndef TKS_DEFINES_SVH
`define TKS_DEFINES_SVH
// register byte offsets
`define TKS_OFF_GCTL 8'h00
`define TKS_OFF_IEN 8'h04
`define TKS_OFF_ISTS 8'h08
`define TKS_OFF_ICLR 8'h0C
`define TKS_OFF_MCTL 8'h10
`define TKS_OFF_REFC 8'h20
`define TKS_OFF_SENSE 8'h40
`define TKS_OFF_END 8'h80
// field positions
`define TKS_GCTL_START 0
`define TKS_GCTL_SHARED 1
`define TKS_GCTL_RUNNING 2
`define TKS_MCTL_TSS 7
`define TKS_MCTL_ROEN 5
`define TKS_MCTL_KOEN 4
`define TKS_MCTL_RELOAD 8
// reset values
`define TKS_MCTL_RST 8'h00
`define TKS_RELOAD_RST 8'h00
// system clock division for the alternative slot clock
`define TKS_SYS_DIV 4
`define TKS_RESP_OK 2'b00
`define TKS_RESP_ERR 2'b10
`endif

/* rtl/tks_pkg.sv */
// types of the touch key scan control block
package tks_pkg;
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_RUN = 2'b10
  } tks_phase_t;
  typedef struct packed {
    tks_phase_t phase;
    logic start;
    logic start_q;
    logic shared_sel;
    logic [3:0][7:0] mctl;
    logic [3:0][7:0] reload;
    logic [3:0][7:0] tmr8;
    logic [3:0][4:0] slot5;
    logic [3:0][15:0] refc;
    logic [15:0][15:0] sense;
    logic [15:0][15:0] result;
    logic [3:0] done;
    logic [1:0] div;
    logic ists;
    logic ien;
    logic aw_have;
    logic w_have;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } tks_state_t;
endpackage

/* rtl/tks_top.sv */
// touch key scan control with an AXI4-Lite register slave
`timescale 1ns/1ns
`include "tks_defines.svh"
module tks_top #(
  parameter int NUM_MOD = 4,
  parameter int KEYS_PER_MOD = 4
) (
  input wire logic core_clk_i, // system clock, 100 MHz
  input wire logic reset_n_i, // async reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [15:0] sense_tick_i, // one pulse per sense osc cycle
  input wire logic [3:0] ref_tick_i, // one pulse per reference osc cycle
  output logic [15:0] key_pin_sel_o, // 1: pin routed to touch input
  output logic [15:0] sense_osc_run_o, // sense oscillator run enable
  output logic [3:0] ref_osc_run_o, // reference oscillator run enable
  output logic irq_o // touch interrupt, level
);

  // ****************************************************************
  // state and decoded controls
  // ****************************************************************
  tks_pkg::tks_state_t st_ff;
  tks_pkg::tks_state_t nxt_st;
  logic start_edge;
  logic div_tick;
  logic ev;
  logic [3:0] tick;
  logic [3:0] ovn;
  logic [3:0] part;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic do_wr;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;

  // handshake readies
  assign s_axi_awready = !st_ff.aw_have && !st_ff.bvalid;
  assign s_axi_wready = !st_ff.w_have && !st_ff.bvalid;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp = st_ff.rresp;
  assign s_axi_rdata = st_ff.rdata;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = (st_ff.aw_have || aw_hs) && (st_ff.w_have || w_hs);
  assign wa = aw_hs ? s_axi_awaddr : st_ff.awaddr;
  assign wd = w_hs ? s_axi_wdata : st_ff.wdata;
  assign ws = w_hs ? s_axi_wstrb : st_ff.wstrb;

  // slot clock and overflow per module
  assign start_edge = st_ff.start && !st_ff.start_q;
  assign div_tick = (st_ff.div == 2'(`TKS_SYS_DIV - 1));
  always_comb begin
    for (int n = 0; n < NUM_MOD; n++) begin
      tick[n] = st_ff.mctl[n][`TKS_MCTL_TSS] ? div_tick : ref_tick_i[0];
      ovn[n] = (st_ff.phase == tks_pkg::PH_RUN) && tick[n] && !st_ff.done[n]
        && (st_ff.tmr8[n] == 8'hFF) && (st_ff.slot5[n] == 5'h1F);
      part[n] = st_ff.mctl[n][`TKS_MCTL_KOEN] && (|st_ff.mctl[n][3:0]);
    end
  end

  // measurement end: module 0 alone, or all taking part modules
  assign ev = (st_ff.phase == tks_pkg::PH_RUN)
    && (st_ff.shared_sel ? ovn[0] : &(st_ff.done | ovn | ~part));

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start_q = st_ff.start;
    nxt_st.div = st_ff.div + 2'h1;
    // measurement phase
    case (st_ff.phase)
      tks_pkg::PH_IDLE: begin
        if (start_edge) begin
          nxt_st.phase = tks_pkg::PH_RUN;
          nxt_st.done = 4'h0;
          nxt_st.result = '0;
        end
      end
      tks_pkg::PH_RUN: begin
        for (int n = 0; n < NUM_MOD; n++) begin
          if (!st_ff.done[n]) begin
            // 8-bit timer then 5-bit slot counter
            if (tick[n]) begin
              if (st_ff.tmr8[n] == 8'hFF) begin
                nxt_st.tmr8[n] = st_ff.reload[n];
                nxt_st.slot5[n] = st_ff.slot5[n] + 5'h01;
                if (st_ff.slot5[n] == 5'h1F) begin
                  nxt_st.done[n] = 1'b1;
                end
              end else begin
                nxt_st.tmr8[n] = st_ff.tmr8[n] + 8'h01;
              end
            end
            if (ref_tick_i[n] && st_ff.mctl[n][`TKS_MCTL_ROEN]) begin
              nxt_st.refc[n] = st_ff.refc[n] + 16'h0001;
            end
            for (int j = 0; j < KEYS_PER_MOD; j++) begin
              if (sense_tick_i[n * 4 + j] && st_ff.mctl[n][j] && st_ff.mctl[n][`TKS_MCTL_KOEN]) begin
                nxt_st.sense[n * 4 + j] = st_ff.sense[n * 4 + j] + 16'h0001;
              end
            end
          end
        end
        if (ev) begin
          nxt_st.phase = tks_pkg::PH_IDLE;
          nxt_st.done = 4'hF;
          nxt_st.result = nxt_st.sense;
          nxt_st.sense = '0;
          nxt_st.refc = '0;
          nxt_st.slot5 = '0;
          nxt_st.tmr8 = '0;
        end else if (!st_ff.start) begin
          nxt_st.phase = tks_pkg::PH_IDLE;
        end
      end
      default: begin
        nxt_st.phase = tks_pkg::PH_IDLE;
      end
    endcase
    // start low holds counters cleared, 8-bit timer untouched
    if (!st_ff.start) begin
      nxt_st.sense = '0;
      nxt_st.refc = '0;
      nxt_st.slot5 = '0;
    end
    // write channel
    if (aw_hs) begin
      nxt_st.aw_have = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      nxt_st.w_have = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_st.aw_have = 1'b0;
      nxt_st.w_have = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = `TKS_RESP_OK;
      if (wa == `TKS_OFF_GCTL) begin
        if (ws[0]) begin
          nxt_st.start = wd[`TKS_GCTL_START];
          nxt_st.shared_sel = wd[`TKS_GCTL_SHARED];
        end
      end else if (wa == `TKS_OFF_IEN) begin
        if (ws[0]) begin
          nxt_st.ien = wd[0];
        end
      end else if (wa == `TKS_OFF_ICLR) begin
        if (ws[0] && wd[0]) begin
          nxt_st.ists = 1'b0;
        end
      end else if (wa == `TKS_OFF_ISTS) begin
        nxt_st.bresp = `TKS_RESP_OK;
      end else if (wa >= `TKS_OFF_MCTL && wa < `TKS_OFF_REFC && wa[1:0] == 2'b00) begin
        if (ws[0]) begin
          nxt_st.mctl[wa[3:2]] = wd[7:0] & 8'hBF;
        end
        if (ws[1]) begin
          nxt_st.reload[wa[3:2]] = wd[15:8];
        end
      end else if (wa >= `TKS_OFF_REFC && wa < `TKS_OFF_END && wa[1:0] == 2'b00) begin
        nxt_st.bresp = `TKS_RESP_OK;
      end else begin
        nxt_st.bresp = `TKS_RESP_ERR;
      end
    end
    // event wins over a clear in the same cycle
    if (ev) begin
      nxt_st.ists = 1'b1;
    end
    // read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (ar_hs) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = `TKS_RESP_OK;
      nxt_st.rdata = 32'h0000_0000;
      if (s_axi_araddr == `TKS_OFF_GCTL) begin
        nxt_st.rdata[`TKS_GCTL_START] = st_ff.start;
        nxt_st.rdata[`TKS_GCTL_SHARED] = st_ff.shared_sel;
        nxt_st.rdata[`TKS_GCTL_RUNNING] = (st_ff.phase == tks_pkg::PH_RUN);
      end else if (s_axi_araddr == `TKS_OFF_IEN) begin
        nxt_st.rdata[0] = st_ff.ien;
      end else if (s_axi_araddr == `TKS_OFF_ISTS) begin
        nxt_st.rdata[0] = st_ff.ists;
      end else if (s_axi_araddr == `TKS_OFF_ICLR) begin
        nxt_st.rdata = 32'h0000_0000;
      end else if (s_axi_araddr >= `TKS_OFF_MCTL && s_axi_araddr < `TKS_OFF_REFC
                   && s_axi_araddr[1:0] == 2'b00) begin
        nxt_st.rdata[7:0] = st_ff.mctl[s_axi_araddr[3:2]];
        nxt_st.rdata[15:8] = st_ff.reload[s_axi_araddr[3:2]];
      end else if (s_axi_araddr >= `TKS_OFF_REFC && s_axi_araddr < `TKS_OFF_SENSE
                   && s_axi_araddr[1:0] == 2'b00) begin
        nxt_st.rdata[15:0] = st_ff.refc[s_axi_araddr[3:2]];
      end else if (s_axi_araddr >= `TKS_OFF_SENSE && s_axi_araddr < `TKS_OFF_END
                   && s_axi_araddr[1:0] == 2'b00) begin
        nxt_st.rdata[15:0] = st_ff.result[s_axi_araddr[5:2]];
      end else begin
        nxt_st.rresp = `TKS_RESP_ERR;
      end
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= '0;
      st_ff.phase <= tks_pkg::PH_IDLE;
      st_ff.mctl <= {4{`TKS_MCTL_RST}};
      st_ff.reload <= {4{`TKS_RELOAD_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_comb begin
    for (int n = 0; n < NUM_MOD; n++) begin
      ref_osc_run_o[n] = (st_ff.phase == tks_pkg::PH_RUN) && !st_ff.done[n]
        && st_ff.mctl[n][`TKS_MCTL_ROEN];
      for (int j = 0; j < KEYS_PER_MOD; j++) begin
        key_pin_sel_o[n * 4 + j] = st_ff.mctl[n][j];
        sense_osc_run_o[n * 4 + j] = (st_ff.phase == tks_pkg::PH_RUN) && !st_ff.done[n]
          && st_ff.mctl[n][`TKS_MCTL_KOEN] && st_ff.mctl[n][j];
      end
    end
  end
  assign irq_o = st_ff.ists && st_ff.ien;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_start_low_clear;
    !st_ff.start |=> (st_ff.slot5 == '0) && (st_ff.refc == '0) && (st_ff.sense == '0);
  endproperty
  a_start_low_clear: assert property (p_start_low_clear) else $error("counters not cleared");

  property p_tmr_kept;
    (st_ff.phase == tks_pkg::PH_IDLE) |=> $stable(st_ff.tmr8);
  endproperty
  a_tmr_kept: assert property (p_tmr_kept) else $error("slot timer changed while idle");

  property p_start_run;
    (start_edge && st_ff.phase == tks_pkg::PH_IDLE) |=> (st_ff.phase == tks_pkg::PH_RUN) && (st_ff.done == 4'h0);
  endproperty
  a_start_run: assert property (p_start_run) else $error("start edge did not run");

  property p_ovf_stop;
    ev |=> (sense_osc_run_o == 16'h0000) && (ref_osc_run_o == 4'h0);
  endproperty
  a_ovf_stop: assert property (p_ovf_stop) else $error("oscillators still running");

  property p_irq;
    (ev && st_ff.ien) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt after overflow");

  property p_clear;
    ev |=> (st_ff.tmr8 == '0) && (st_ff.slot5 == '0) && (st_ff.refc == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("counters kept after interrupt");

  property p_flag;
    (st_ff.phase == tks_pkg::PH_RUN && !ev && st_ff.start) |=> (st_ff.phase == tks_pkg::PH_RUN);
  endproperty
  a_flag: assert property (p_flag) else $error("running flag fell early");

  property p_result;
    ev |=> (st_ff.result[0] == $past(st_ff.sense[0])
      + {15'h0000, $past(sense_tick_i[0] && sense_osc_run_o[0])});
  endproperty
  a_result: assert property (p_result) else $error("result not latched");

  c_start: cover property (start_edge);
  c_event: cover property (ev);
  c_irq: cover property (irq_o);
  c_shared: cover property (ev && st_ff.shared_sel);
endmodule

/* verif/tb_touch_key_scan_control.sv */
// self-checking bench for the touch key scan control block
`timescale 1ns/1ns
module tb_touch_key_scan_control;
  // ****************************************
  // signals, design and oscillator model
  // ****************************************
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, clr = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] rdata, v;
  logic [1:0] bresp, rresp;
  logic [15:0] stick, pin_sel, srun, exp_sel;
  logic [3:0] rtick, rrun;
  int cnt [16];
  int err_total = 0, tests_run = 0, dur_sys, dur_ref;
  logic [33:0] rq [$];
  logic [1:0] bq [$];

  tks_top u_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sense_tick_i(stick), .ref_tick_i(rtick), .key_pin_sel_o(pin_sel), .sense_osc_run_o(srun),
    .ref_osc_run_o(rrun), .irq_o(irq));
  tks_osc_model u_osc (.clk_i(core_clk_i), .reset_n_i(reset_n_i), .clr_i(clr), .sense_run_i(srun),
    .ref_run_i(rrun), .sense_tick_o(stick), .ref_tick_o(rtick), .cnt_o(cnt));

  // ****************************************
  // clock, bus tasks and result monitor
  // ****************************************
  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge core_clk_i);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    @(posedge core_clk_i);
    rq.push_back({er, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk_i);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask
  // oldest noted answer is compared at each response handshake
  always @(posedge core_clk_i) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
  end
  // start a window and time it on the module 0 reference enable
  task automatic meas(input logic [31:0] g, input logic [15:0] er, output int dur);
    @(posedge core_clk_i);
    clr <= 1'b1;
    @(posedge core_clk_i);
    clr <= 1'b0;
    wr(8'h00, g);
    repeat (3) @(posedge core_clk_i);
    chk(34'(srun), 34'(er));
    rd(8'h00, g | 32'h4);
    dur = 0;
    while (rrun[0]) begin
      @(posedge core_clk_i);
      dur++;
    end
    @(posedge core_clk_i);
    chk(34'({srun, rrun}), 34'h0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the longest expected run
  initial begin
    #(90000 * 10);
    err_total++;
    wrap_up();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    void'($urandom(64843));
    repeat (6) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    for (int n = 0; n < 4; n++) rd(8'h10 + 8'(4 * n), 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h80, 32'h0, 2'h2);
    wr(8'h84, 32'hFF, 2'h2);
    $display("test reset and decode done");
    for (int n = 0; n < 4; n++) begin
      v = $urandom();
      wr(8'h10 + 8'(4 * n), v);
      rd(8'h10 + 8'(4 * n), {16'h0, v[15:8], v[7:0] & 8'hBF});
      exp_sel[4 * n +: 4] = v[3:0];
    end
    chk(34'(pin_sel), 34'(exp_sel));
    $display("test control registers done");
    for (int n = 0; n < 4; n++) wr(8'h10 + 8'(4 * n), 32'hFFBF);
    // byte strobes: only the reload byte may change
    wstrb <= 4'h2;
    wr(8'h10, 32'h7700);
    wstrb <= 4'hF;
    rd(8'h10, 32'h77BF);
    wr(8'h10, 32'hFFBF);
    wr(8'h04, 32'h0);
    meas(32'h3, 16'hFFFF, dur_sys);
    chk(34'(irq), 34'h0);
    rd(8'h08, 32'h1);
    rd(8'h00, 32'h3);
    rd(8'h20, 32'h0);
    for (int k = 0; k < 16; k++) rd(8'h40 + 8'(4 * k), 32'(cnt[k]));
    wr(8'h04, 32'h1);
    chk(34'(irq), 34'h1);
    wr(8'h0C, 32'h1);
    chk(34'(irq), 34'h0);
    $display("test shared window done");
    wr(8'h00, 32'h0);
    wr(8'h10, 32'hFF31);
    wr(8'h14, 32'hFF33);
    wr(8'h18, 32'hFF20);
    wr(8'h1C, 32'hFF0F);
    chk(34'(pin_sel), 34'hF031);
    meas(32'h1, 16'h0031, dur_ref);
    chk(34'(irq), 34'h1);
    for (int k = 0; k < 16; k++) rd(8'h40 + 8'(4 * k), 32'(cnt[k]));
    chk(34'(dur_sys > dur_ref * 3 / 2), 34'h1);
    wr(8'h0C, 32'h1);
    $display("test per-module window done");
    wr(8'h00, 32'h0);
    wr(8'h00, 32'h1);
    repeat (20) @(posedge core_clk_i);
    wr(8'h00, 32'h0);
    repeat (5) @(posedge core_clk_i);
    chk(34'({srun, rrun, irq}), 34'h0);
    rd(8'h20, 32'h0);
    rd(8'h08, 32'h0);
    $display("test abort done");
    repeat (3) @(posedge core_clk_i);
    wrap_up();
  end
endmodule

/* verif/tks_osc_model.sv */
// behavioural touch pad oscillators feeding sense and reference ticks
`timescale 1ns/1ns
module tks_osc_model (
  input wire logic clk_i, // system clock
  input wire logic reset_n_i, // async reset, active low
  input wire logic clr_i, // zero the pulse tallies
  input wire logic [15:0] sense_run_i, // sense oscillator run enables
  input wire logic [3:0] ref_run_i, // reference oscillator run enables
  output logic [15:0] sense_tick_o, // one pulse per sense cycle
  output logic [3:0] ref_tick_o, // one pulse per reference cycle
  output int cnt_o [16] // sense pulses handed over while running
);
  int ph [20];
  logic [19:0] tk;
  wire [19:0] run = {ref_run_i, sense_run_i};
  assign sense_tick_o = tk[15:0];
  assign ref_tick_o = tk[19:16];
  // keys run at 2..4 cycles per tick, reference at 2, so rates differ
  function automatic int per(input int i);
    return (i < 16) ? 2 + i % 3 : 2;
  endfunction
  // a stopped oscillator falls back to phase 0 and gives no pulse
  always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tk <= '0;
      for (int i = 0; i < 20; i++) ph[i] <= 0;
      for (int i = 0; i < 16; i++) cnt_o[i] <= 0;
    end else begin
      for (int i = 0; i < 20; i++) begin
        ph[i] <= (run[i] && ph[i] < per(i) - 1) ? ph[i] + 1 : 0;
        tk[i] <= run[i] && ph[i] == per(i) - 1;
      end
      for (int i = 0; i < 16; i++) cnt_o[i] <= clr_i ? 0 : cnt_o[i] + int'(tk[i] && run[i]);
    end
  end
endmodule
